// ==== core/edhc_pkg.sv ====
/*
  constants, field layout and reset values shared by the flag recode and
  control block. assumes a 100 MHz core clock and word aligned bus access.
*/
package edhc_pkg;
  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int FLAG_W = 15;
  localparam int CLASS_W = 5;
  localparam int CLASS_N = 3;
  localparam int CNT_W = 21;
  localparam int SENS_W = 13;
  localparam int RW_N = 7;
  localparam int RW_BITS = 6;
  localparam int RW_WORD = 10;
  localparam int CTRL_W = 9;

  // --------------------------------------------------------------------
  // flag kinds within a class; classes ancillary, picture, full field
  // --------------------------------------------------------------------
  localparam int KIND_ERR_HERE = 0;
  localparam int KIND_ERR_ALREADY = 1;
  localparam int KIND_INT_HERE = 2;
  localparam int KIND_INT_ALREADY = 3;
  localparam int KIND_UNKNOWN = 4;
  localparam int CLS_ANC = 0;
  localparam int CLS_PIC = 1;
  localparam int CLS_FULL = 2;

  // --------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_SENS = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_RW_LO = 8'h14;
  localparam logic [7:0] ADDR_RW_HI = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam int RW_LO_W = 30;

  // control bit positions
  localparam int CB_STICKY = 0;
  localparam int CB_MASK_RW = 1;
  localparam int CB_TIMING_REF_INDICATION_SELECT = 2;
  localparam int CB_CNT_CLR = 3;
  localparam int CB_CLR_READ = 4;
  localparam int CB_STD_OVR = 5;
  localparam int CB_LINE = 6;
  localparam int CB_LUMA = 7;
  localparam int CB_COMP = 8;

  // reset values and strap decode
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [FLAG_W-1:0] MASK_RST = 15'h0000;
  localparam logic [SENS_W-1:0] SENS_RST = 13'h1fff;
  localparam logic [1:0] STRAP_TRS = 2'h1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef logic [FLAG_W-1:0] edhc_flags_t;

  // sensitivity: four per class, then one shared unknown-status bit
  function automatic edhc_flags_t edhcExpandSens(logic [SENS_W-1:0] s);
    edhc_flags_t v;
    v = '0;
    for (int c = 0; c < CLASS_N; c++) begin
      v[c*CLASS_W +: 4] = s[c*4 +: 4];
      v[c*CLASS_W + KIND_UNKNOWN] = s[SENS_W-1];
    end
    return v;
  endfunction : edhcExpandSens
endpackage : edhc_pkg

// ==== core/edhc_rw_if.sv ====
/*
  carries reserved word settings to the encoder and encoded words back.
  assumes both ends run on the core clock.
*/
`timescale 1ns/100ps
interface edhc_rw_if;
  import edhc_pkg::*;
  logic maskRw;
  logic [RW_N*RW_BITS-1:0] written;
  logic [RW_N*RW_WORD-1:0] rxWords;
  logic [RW_N*RW_WORD-1:0] txWords;
  modport ctl (output maskRw, output written, output rxWords, input txWords);
  modport enc (input maskRw, input written, input rxWords, output txWords);
endinterface : edhc_rw_if

// ==== core/edhc_rw_encode.sv ====
/*
  reserved word encoder: parity and pad bits on written values, or pass
  the received words through. assumes words arrive on the core clock.
*/
`timescale 1ns/100ps
module edhc_rw_encode
  import edhc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  edhc_rw_if.enc rwBus
);
  // even parity in bit 8, inverse in bit 9, low two bits zero
  function automatic logic [RW_WORD-1:0] encodeWord(logic [RW_BITS-1:0] b);
    logic p;
    p = ^b;
    return {~p, p, b, 2'b00};
  endfunction : encodeWord

  // --------------------------------------------------------------------
  // outgoing reserved words
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rwBus.txWords <= '0;
    end else if (clkEn) begin
      for (int i = 0; i < RW_N; i++) begin
        rwBus.txWords[i*RW_WORD +: RW_WORD] <= rwBus.maskRw ?
          encodeWord(rwBus.written[i*RW_BITS +: RW_BITS]) :
          rwBus.rxWords[i*RW_WORD +: RW_WORD];
      end
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  rwOverride_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && rwBus.maskRw |=> rwBus.txWords[RW_WORD-1:0] ==
      encodeWord($past(rwBus.written[RW_BITS-1:0])))
    else $error("reserved word not replaced by written value");
  rwParity_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && rwBus.maskRw |=> rwBus.txWords[RW_N*RW_WORD-9 -: 2] == 2'b00 &&
      (^rwBus.txWords[RW_N*RW_WORD-2 -: RW_BITS+1]) == 1'b0 &&
      rwBus.txWords[RW_N*RW_WORD-1] != rwBus.txWords[RW_N*RW_WORD-2])
    else $error("reserved word parity or pad bits wrong");
endmodule : edhc_rw_encode

// ==== core/edhc_control.sv ====
/*
  control registers, flag recode, sticky flags, errored field counter and
  standard select of the error detection coprocessor, on an ahb-lite slave.
  assumes stream strobes come from logic on core_clk; straps are pins.
*/
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module edhc_control
  import edhc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic fieldEnd,
  input wire logic rxPacketPresent,
  input wire logic [FLAG_W-1:0] rxFlags,
  input wire logic ancChecksumErr,
  input wire logic picCrcMismatch,
  input wire logic fullCrcMismatch,
  input wire logic [CLASS_N-1:0] localIntErr,
  input wire logic detLineRate,
  input wire logic detLumaRate,
  input wire logic detComposite,
  input wire logic ancDataIn,
  input wire logic trsIn,
  input wire logic strapAddressHigh,
  input wire logic strapAddressLow,
  input wire logic [RW_N*RW_WORD-1:0] rxRwWords,
  output logic [FLAG_W-1:0] txFlags,
  output logic [RW_N*RW_WORD-1:0] txRwWords,
  output logic flagAlert,
  output logic ancIndication,
  output logic lineRateSelect,
  output logic lumaRateSelect,
  output logic compositeComponentSelect
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic [FLAG_W-1:0] mask_reg;
  logic [SENS_W-1:0] sens_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] txFlags_reg;
  logic [CNT_W-1:0] count_reg;
  logic [RW_N*RW_BITS-1:0] rw_reg;
  logic [1:0] strapMeta_reg;
  logic [1:0] strapSync_reg;
  logic [1:0] strapWait_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  logic alert_reg;
  logic anc_reg;
  logic [2:0] std_reg;
  logic busAccept;
  logic rdFlags;
  logic rdCount;
  logic [31:0] rdMux;
  logic [FLAG_W-1:0] localFlags;
  logic [FLAG_W-1:0] newFlags;
  logic [FLAG_W-1:0] sensVec;
  logic fieldHit;
  edhc_rw_if rwBus ();

  // --------------------------------------------------------------------
  // ahb-lite slave: zero wait state, always okay
  // --------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign busAccept = hsel && hready && htrans == HTRANS_NONSEQ && clkEn;
  assign rdFlags = busAccept && !hwrite && haddr[7:0] == ADDR_FLAGS;
  assign rdCount = busAccept && !hwrite && haddr[7:0] == ADDR_COUNT;

  // address phase capture for writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else if (clkEn) begin
      wrPend_reg <= busAccept && hwrite;
      wrAddr_reg <= haddr[7:0];
    end
  end

  // read data mux, unmapped reads zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CTRL: rdMux[CTRL_W-1:0] = ctrl_reg;
      ADDR_MASK: rdMux[FLAG_W-1:0] = mask_reg;
      ADDR_SENS: rdMux[SENS_W-1:0] = sens_reg;
      ADDR_FLAGS: rdMux[FLAG_W-1:0] = flags_reg;
      ADDR_COUNT: rdMux[CNT_W-1:0] = count_reg;
      ADDR_RW_LO: rdMux[RW_LO_W-1:0] = rw_reg[RW_LO_W-1:0];
      ADDR_RW_HI: rdMux[RW_N*RW_BITS-RW_LO_W-1:0] = rw_reg[RW_N*RW_BITS-1:RW_LO_W];
      ADDR_STATUS: rdMux[3:0] = {!rxPacketPresent, std_reg};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // read data registered at address phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (busAccept && !hwrite) begin
      hrdata_reg <= rdMux;
    end
  end

  // --------------------------------------------------------------------
  // strap pins: two flops, then sampled once after reset
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strapMeta_reg <= 2'h0;
      strapSync_reg <= 2'h0;
    end else if (clkEn) begin
      strapMeta_reg <= {strapAddressHigh, strapAddressLow};
      strapSync_reg <= strapMeta_reg;
    end
  end

  // control word; strap check precedes any host write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      strapWait_reg <= 2'h0;
    end else if (clkEn) begin
      if (strapWait_reg != STRAP_WAIT) begin
        strapWait_reg <= strapWait_reg + 2'h1;
      end
      if (strapWait_reg == STRAP_WAIT - 2'h1 && strapSync_reg == STRAP_TRS) begin
        ctrl_reg[CB_TIMING_REF_INDICATION_SELECT] <= 1'b1;
      end
      if (wrPend_reg && wrAddr_reg == ADDR_CTRL) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
    end
  end

  // mask, sensitivity and reserved word settings
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mask_reg <= MASK_RST;
      sens_reg <= SENS_RST;
      rw_reg <= '0;
    end else if (clkEn && wrPend_reg) begin
      if (wrAddr_reg == ADDR_MASK) mask_reg <= hwdata[FLAG_W-1:0];
      if (wrAddr_reg == ADDR_SENS) sens_reg <= hwdata[SENS_W-1:0];
      if (wrAddr_reg == ADDR_RW_LO) rw_reg[RW_LO_W-1:0] <= hwdata[RW_LO_W-1:0];
      if (wrAddr_reg == ADDR_RW_HI) begin
        rw_reg[RW_N*RW_BITS-1:RW_LO_W] <= hwdata[RW_N*RW_BITS-RW_LO_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // flag recode for the outgoing packet
  // --------------------------------------------------------------------
  always_comb begin
    localFlags = '0;
    for (int c = 0; c < CLASS_N; c++) begin
      localFlags[c*CLASS_W + KIND_ERR_ALREADY] = rxPacketPresent &&
        (rxFlags[c*CLASS_W + KIND_ERR_HERE] || rxFlags[c*CLASS_W + KIND_ERR_ALREADY]);
      localFlags[c*CLASS_W + KIND_INT_ALREADY] = rxPacketPresent &&
        (rxFlags[c*CLASS_W + KIND_INT_HERE] || rxFlags[c*CLASS_W + KIND_INT_ALREADY]);
      localFlags[c*CLASS_W + KIND_INT_HERE] = localIntErr[c];
      localFlags[c*CLASS_W + KIND_UNKNOWN] = !rxPacketPresent;
    end
    localFlags[CLS_ANC*CLASS_W + KIND_ERR_HERE] = ancChecksumErr;
    localFlags[CLS_PIC*CLASS_W + KIND_ERR_HERE] = picCrcMismatch;
    localFlags[CLS_FULL*CLASS_W + KIND_ERR_HERE] = fullCrcMismatch;
  end

  assign newFlags = localFlags & ~mask_reg;
  assign sensVec = edhcExpandSens(sens_reg);
  assign fieldHit = fieldEnd && (newFlags & sensVec) != '0;

  // outgoing flags, one field at a time
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txFlags_reg <= '0;
    end else if (clkEn && fieldEnd) begin
      txFlags_reg <= newFlags;
    end
  end
  assign txFlags = txFlags_reg;

  // host flag register; a new field wins over a clearing read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_reg <= '0;
    end else if (clkEn) begin
      if (ctrl_reg[CB_STICKY]) begin
        flags_reg <= (rdFlags ? '0 : flags_reg) | (fieldEnd ? newFlags : '0);
      end else if (fieldEnd) begin
        flags_reg <= newFlags;
      end
    end
  end

  // alert level from sensitive flags
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alert_reg <= 1'b0;
    end else if (clkEn) begin
      alert_reg <= (flags_reg & sensVec) != '0;
    end
  end
  assign flagAlert = alert_reg;

  // --------------------------------------------------------------------
  // errored field counter
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (clkEn) begin
      if (ctrl_reg[CB_CNT_CLR]) begin
        count_reg <= '0;
      end else if (rdCount && ctrl_reg[CB_CLR_READ]) begin
        count_reg <= fieldHit ? CNT_W'(1) : '0;
      end else if (fieldHit) begin
        count_reg <= count_reg + CNT_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------
  // standard select and ancillary indication
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      std_reg <= 3'h0;
      anc_reg <= 1'b0;
    end else if (clkEn) begin
      std_reg <= ctrl_reg[CB_STD_OVR] ?
        {ctrl_reg[CB_COMP], ctrl_reg[CB_LUMA], ctrl_reg[CB_LINE]} :
        {detComposite, detLumaRate, detLineRate};
      anc_reg <= ancDataIn || (ctrl_reg[CB_TIMING_REF_INDICATION_SELECT] && trsIn);
    end
  end
  assign lineRateSelect = std_reg[0];
  assign lumaRateSelect = std_reg[1];
  assign compositeComponentSelect = std_reg[2];
  assign ancIndication = anc_reg;

  // --------------------------------------------------------------------
  // reserved word encoder
  // --------------------------------------------------------------------
  assign rwBus.maskRw = ctrl_reg[CB_MASK_RW];
  assign rwBus.written = rw_reg;
  assign rwBus.rxWords = rxRwWords;
  assign txRwWords = rwBus.txWords;

  edhc_rw_encode rwEncode (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .rwBus(rwBus.enc)
  );

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  maskSuppress_a: assert property (clkEn && fieldEnd |=>
    (txFlags & $past(mask_reg)) == '0)
    else $error("masked flag reported");
  stickyHold_a: assert property (clkEn && ctrl_reg[CB_STICKY] && !rdFlags |=>
    ($past(flags_reg) & ~flags_reg) == '0)
    else $error("sticky flag dropped without read");
  counterHold_a: assert property (clkEn && ctrl_reg[CB_CNT_CLR] |=>
    count_reg == '0 ##1 (!clkEn || !ctrl_reg[CB_CNT_CLR] || count_reg == '0))
    else $error("counter not held at zero");
  counterStep_a: assert property (clkEn && fieldHit && !ctrl_reg[CB_CNT_CLR] &&
    !rdCount |=> count_reg == $past(count_reg) + CNT_W'(1))
    else $error("errored field not counted");
  readClear_a: assert property (clkEn && rdCount && ctrl_reg[CB_CLR_READ] &&
    !fieldHit |=> count_reg == '0)
    else $error("counter not cleared by read");
  unknownStatus_a: assert property (clkEn && fieldEnd && !rxPacketPresent &&
    mask_reg == '0 |=> txFlags[CLS_FULL*CLASS_W + KIND_UNKNOWN]
      && txFlags[CLS_PIC*CLASS_W + KIND_UNKNOWN])
    else $error("missing packet not flagged");
  recodeHere_a: assert property (clkEn && fieldEnd && rxPacketPresent &&
    rxFlags[CLS_PIC*CLASS_W + KIND_ERR_HERE] && mask_reg == '0
    |=> txFlags[CLS_PIC*CLASS_W + KIND_ERR_ALREADY])
    else $error("error-here not recoded");
  recodeInternal_a: assert property (clkEn && fieldEnd && rxPacketPresent &&
    rxFlags[CLS_ANC*CLASS_W + KIND_INT_HERE] && mask_reg == '0
    |=> txFlags[CLS_ANC*CLASS_W + KIND_INT_ALREADY])
    else $error("internal-here not recoded");
  crcHere_a: assert property (clkEn && fieldEnd && fullCrcMismatch &&
    !mask_reg[CLS_FULL*CLASS_W + KIND_ERR_HERE] |=> txFlags[CLS_FULL*CLASS_W + KIND_ERR_HERE])
    else $error("crc mismatch not flagged");
  stdSelect_a: assert property (clkEn && !ctrl_reg[CB_STD_OVR] |=>
    lineRateSelect == $past(detLineRate) && compositeComponentSelect == $past(detComposite))
    else $error("autodetected standard not used");
  ancPin_a: assert property (clkEn |=> ancIndication ==
    ($past(ancDataIn) || ($past(ctrl_reg[CB_TIMING_REF_INDICATION_SELECT]) && $past(trsIn))))
    else $error("ancillary indication wrong");
  resetDefault_a: assert property (disable iff (1'b0) sys_rst |=>
    sens_reg == SENS_RST && ctrl_reg == CTRL_RST && mask_reg == MASK_RST)
    else $error("power-up defaults wrong");

  fieldCount_c: cover property (clkEn && fieldHit && !ctrl_reg[CB_CNT_CLR]);
  stickyRead_c: cover property (clkEn && ctrl_reg[CB_STICKY] && rdFlags && flags_reg != '0);
  strapTrs_c: cover property (strapWait_reg == STRAP_WAIT && ctrl_reg[CB_TIMING_REF_INDICATION_SELECT]);
  stdOverride_c: cover property (clkEn && ctrl_reg[CB_STD_OVR] && fieldEnd);
endmodule : edhc_control

// ==== sim/edhc_field_src.sv ====
/*
  field source model: drives one field's received flags, link error levels
  and the received reserved words. assumes core_clk comes from the bench.
*/
`timescale 1ns/100ps
module edhc_field_src
  import edhc_pkg::*;
(
  input wire logic core_clk,
  output logic fieldEnd,
  output logic rxPacketPresent,
  output logic [FLAG_W-1:0] rxFlags,
  output logic [2:0] crcErr,
  output logic [CLASS_N-1:0] localIntErr,
  output logic [RW_N*RW_WORD-1:0] rxRwWords
);
  // idle levels at time zero
  initial begin
    fieldEnd = 1'b0;
    {rxPacketPresent, rxFlags, crcErr, localIntErr} = '0;
    rxRwWords = '0;
  end

  // one field strobe; afterwards the lines show the inverse of the last value
  task automatic sendField(input logic pr, input logic [FLAG_W-1:0] fl, input logic [2:0] ce,
      input logic [CLASS_N-1:0] li);
    @(posedge core_clk);
    fieldEnd <= 1'b1;
    {rxPacketPresent, rxFlags, crcErr, localIntErr} <= {pr, fl, ce, li};
    @(posedge core_clk);
    fieldEnd <= 1'b0;
    {rxPacketPresent, rxFlags, crcErr, localIntErr} <= ~{pr, fl, ce, li};
  endtask : sendField

  // reserved words carried by the incoming packet
  task automatic setWords(input logic [RW_N*RW_WORD-1:0] w);
    @(posedge core_clk);
    rxRwWords <= w;
  endtask : setWords
endmodule : edhc_field_src

// ==== sim/edh_control_and_flag_recode_tb.sv ====
/*
  self-checking bench for edhc_control: bus registers, flag recode, sticky
  flags, field counter, standard select, reserved words. assumes edhc_pkg.
*/
`timescale 1ns/100ps
module edh_control_and_flag_recode_tb
  import edhc_pkg::*;
;
  logic core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, fieldEnd, rxPacketPresent;
  logic ancDataIn, trsIn, detLine, detLuma, detComp, strapHi, strapLo, clkEn;
  logic flagAlert, ancIndication, lineSel, lumaSel, compSel;
  logic sticky, clrCnt, clrRead, rdAcc, feSeen, feSeen2;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [2:0] crcErr, localIntErr, stdExp;
  logic [FLAG_W-1:0] rxFlags, txFlags, mask, modelFlags;
  logic [SENS_W-1:0] sens;
  logic [CNT_W-1:0] cnt;
  logic [41:0] rwBits;
  logic [RW_N*RW_WORD-1:0] rxRwWords, txRwWords, rwExp;
  logic [31:0] rdQ[$];
  logic [FLAG_W:0] feQ[$];
  int err_total, total_checks;

  edhc_control dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fieldEnd(fieldEnd),
    .rxPacketPresent(rxPacketPresent), .rxFlags(rxFlags), .ancChecksumErr(crcErr[0]),
    .picCrcMismatch(crcErr[1]), .fullCrcMismatch(crcErr[2]), .localIntErr(localIntErr),
    .detLineRate(detLine), .detLumaRate(detLuma), .detComposite(detComp),
    .ancDataIn(ancDataIn), .trsIn(trsIn), .strapAddressHigh(strapHi),
    .strapAddressLow(strapLo), .rxRwWords(rxRwWords), .txFlags(txFlags),
    .txRwWords(txRwWords), .flagAlert(flagAlert), .ancIndication(ancIndication),
    .lineRateSelect(lineSel), .lumaRateSelect(lumaSel), .compositeComponentSelect(compSel)
  );

  edhc_field_src src_u (
    .core_clk(core_clk), .fieldEnd(fieldEnd), .rxPacketPresent(rxPacketPresent),
    .rxFlags(rxFlags), .crcErr(crcErr), .localIntErr(localIntErr), .rxRwWords(rxRwWords)
  );

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected outgoing flags of one field
  function automatic logic [FLAG_W-1:0] recodeExp(input logic pr, input logic [FLAG_W-1:0] rx,
      input logic [2:0] ce, input logic [2:0] li);
    logic [FLAG_W-1:0] v;
    v = '0;
    for (int c = 0; c < 3; c++) begin
      v[c*5] = ce[c];
      v[c*5+1] = pr & (rx[c*5] | rx[c*5+1]);
      v[c*5+2] = li[c];
      v[c*5+3] = pr & (rx[c*5+2] | rx[c*5+3]);
      v[c*5+4] = !pr;
    end
    return v;
  endfunction : recodeExp

  // sensitivity spread over the flag positions
  function automatic logic [FLAG_W-1:0] sensSpread(input logic [SENS_W-1:0] s);
    logic [FLAG_W-1:0] v;
    for (int c = 0; c < 3; c++) begin
      v[c*5 +: 4] = s[c*4 +: 4];
      v[c*5+4] = s[12];
    end
    return v;
  endfunction : sensSpread

  task automatic chk(input logic [69:0] seen, input logic [69:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // one single ahb-lite transfer, address phase then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (a == ADDR_CTRL) begin
      {clrRead, clrCnt, sticky} = {d[4:3], d[0]};
      if (d[3]) cnt = '0;
    end
    if (a == ADDR_MASK) mask = d[FLAG_W-1:0];
    if (a == ADDR_SENS) sens = d[SENS_W-1:0];
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task automatic rdFlags();
    rd(ADDR_FLAGS, {17'h0, modelFlags});
    if (sticky) modelFlags = '0;
  endtask : rdFlags

  task automatic rdCount();
    rd(ADDR_COUNT, {11'h0, cnt});
    if (clrRead) cnt = '0;
  endtask : rdCount

  task automatic field(input logic pr, input logic [FLAG_W-1:0] rx, input logic [2:0] ce,
      input logic [2:0] li);
    logic [FLAG_W-1:0] o;
    o = recodeExp(pr, rx, ce, li) & ~mask;
    modelFlags = sticky ? (modelFlags | o) : o;
    if (!clrCnt && |(o & sensSpread(sens))) cnt++;
    feQ.push_back({|(modelFlags & sensSpread(sens)), o});
    src_u.sendField(pr, rx, ce, li);
  endtask : field

  // --------------------------------------------------------------------
  // clock, watcher, watchdog
  // --------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // read data and field results against the oldest notes
  always @(posedge core_clk) begin
    if (rdAcc) chk({hresp, hrdata}, {1'b0, rdQ.pop_front()});
    if (feSeen) chk(txFlags, feQ[0][FLAG_W-1:0]);
    if (feSeen2) chk(flagAlert, feQ.pop_front() >> FLAG_W);
    rdAcc <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
    feSeen <= fieldEnd;
    feSeen2 <= feSeen;
  end

  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {ancDataIn, trsIn, detLine, detLuma, detComp, clkEn} = 6'h01;
    {strapHi, strapLo} = 2'h1;
    {sticky, clrCnt, clrRead, rdAcc, feSeen, feSeen2, mask, modelFlags, cnt} = '0;
    sens = '1;
    rnd = 32'h2bd2b4f5;
    err_total = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(ADDR_CTRL, 32'h4);
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_SENS, 32'h1fff);
    rdCount();
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    for (int t = 0; t < 16; t++) begin
      if (t == 8) wr(ADDR_CTRL, 32'h0);
      rnd = lfsr(rnd);
      @(posedge core_clk);
      {ancDataIn, trsIn} <= rnd[1:0];
      @(posedge core_clk);
      @(negedge core_clk);
      chk(ancIndication, rnd[1] | (t < 8 && rnd[0]));
    end
    // clock enable low: indication must hold its last value
    @(posedge core_clk);
    clkEn <= 1'b0;
    {ancDataIn, trsIn} <= ~rnd[1:0];
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(ancIndication, rnd[1]);
    @(posedge core_clk);
    clkEn <= 1'b1;
    for (int v = 0; v < 12; v++) begin
      rnd = lfsr(rnd);
      wr(ADDR_CTRL, (v < 8) ? (32'h20 | (v << 6)) : 32'h0);
      @(posedge core_clk);
      {detLine, detLuma, detComp} <= rnd[2:0];
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      stdExp = (v < 8) ? v[2:0] : {rnd[0], rnd[1], rnd[2]};
      chk({compSel, lumaSel, lineSel}, stdExp);
      rd(ADDR_STATUS, {28'h1, stdExp});
    end
    for (int f = 0; f < 8; f++) begin
      rnd = lfsr(rnd);
      if (f[1:0] == 2'h0) wr(ADDR_MASK, {17'h0, rnd[31:17]});
      field(rnd[0], rnd[15:1], rnd[18:16], rnd[21:19]);
    end
    rdFlags();
    rdCount();
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_SENS, 32'h1000);
    field(1'b0, '0, 3'h0, 3'h0);
    field(1'b1, '1, 3'h7, 3'h7);
    wr(ADDR_SENS, 32'h1);
    field(1'b1, '0, 3'h1, 3'h0);
    wr(ADDR_CTRL, 32'h10);
    rdCount();
    rdCount();
    wr(ADDR_SENS, 32'h1fff);
    field(1'b0, '0, 3'h0, 3'h0);
    wr(ADDR_CTRL, 32'h8);
    field(1'b0, '0, 3'h0, 3'h0);
    rdCount();
    wr(ADDR_CTRL, 32'h0);
    field(1'b0, '0, 3'h0, 3'h0);
    rdCount();
    wr(ADDR_CTRL, 32'h1);
    field(1'b1, 15'h0001, 3'h0, 3'h0);
    field(1'b1, 15'h0400, 3'h0, 3'h0);
    rdFlags();
    rdFlags();
    rnd = lfsr(rnd);
    rwBits = {rnd[31:20], rnd[29:0]};
    for (int i = 0; i < RW_N; i++) begin
      rwExp[i*RW_WORD +: RW_WORD] = {~^rwBits[i*6 +: 6], ^rwBits[i*6 +: 6],
        rwBits[i*6 +: 6], 2'h0};
    end
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_RW_LO, {2'h0, rnd[29:0]});
    wr(ADDR_RW_HI, {20'h0, rnd[31:20]});
    rd(ADDR_RW_LO, {2'h0, rnd[29:0]});
    rd(ADDR_RW_HI, {20'h0, rnd[31:20]});
    src_u.setWords({rnd, ~rnd, 6'h15});
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(txRwWords, rwExp);
    wr(ADDR_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(txRwWords, {rnd, ~rnd, 6'h15});
    end_sim();
  end
endmodule : edh_control_and_flag_recode_tb
